// File: hdl/video_dif_block_mapper.v
// address generator placing compressed macroblocks into video blocks of a frame
// assumes frame_start and sys_format come from logic on sys_clk (no synchronisers)
//
// How it works
// R1 - 60Hz/720p columns (4h+s+2t+off) mod 10
// R2 - five blocks carry columns a..e, positions 2,1,3,0,4
// R3 - 60Hz: four channels, sequences 0..9, blocks 0..134
// R4 - 1080/50i columns (4h+i+off) mod 11
// R5 - 1080/50i five blocks positions 2,1,3,0,4
// R6 - 1080/50i channel 0 sequence 11 holds edge unit
// R7 - 1080/50i channels 1..3 sequence 11 empty
// R8 - 720/50p sequences 10,11 empty, rest like 60Hz
// R9 - block named by block index, sequence, channel
// R10 - payload is one 77-byte macroblock
// R11 - identifier carries video section type 100
// R12 - frame start restarts counters, latches format
`timescale 1ns/10ps
`include "blk_mapper_map.vh"

module video_dif_block_mapper (
    input wire sys_clk,
    input wire reset,
    input wire frame_start,
    input wire [1:0] sys_format,
    output wire slot_valid,
    input wire slot_ready,
    output wire [1:0] channel,
    output wire [3:0] sequence_index,
    output wire [7:0] block_index_in_sequence,
    output wire mb_present,
    output wire [3:0] mb_column,
    output wire [2:0] mb_position,
    output wire [4:0] mb_order,
    output wire [2:0] section_type,
    output wire [6:0] payload_bytes,
    output reg frame_done
);

    localparam ST_IDLE = 2'h0;
    localparam ST_MAIN = 2'h1;
    localparam ST_EDGE = 2'h2;
    localparam ST_PAD = 2'h3;
    localparam DW = 27;

    reg [1:0] state_r;
    reg [1:0] fmt_r;
    reg [1:0] h_r;
    reg s_r;
    reg [4:0] k_r;
    reg [3:0] t_r;
    reg [2:0] u_r;
    reg [3:0] pseq_r;
    reg [7:0] pblk_r;
    reg [1:0] state_nxt;
    reg [DW-1:0] slot_d;
    reg slot_we;
    wire fifo_ready;
    wire [DW-1:0] fifo_q;
    wire is_50i;
    wire [3:0] colmod;
    wire [10:0] lin;
    wire [7:0] blk_base;
    wire [3:0] seq_main;
    wire [10:0] seq_full;
    wire [10:0] blk_full;
    wire last_u;
    wire last_t;
    wire last_k;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // column offset and position for slot u within a group of five
    function [3:0] col_off;
        input [2:0] u;
        begin
            case (u)
                3'h0: col_off = 4'h2;
                3'h1: col_off = 4'h6;
                3'h2: col_off = 4'h8;
                3'h3: col_off = 4'h0;
                default: col_off = 4'h4;
            endcase
        end
    endfunction

    function [2:0] pos_of;
        input [2:0] u;
        begin
            case (u)
                3'h0: pos_of = 3'h2;
                3'h1: pos_of = 3'h1;
                3'h2: pos_of = 3'h3;
                3'h3: pos_of = 3'h0;
                default: pos_of = 3'h4;
            endcase
        end
    endfunction

    // (x) mod m for x < 3m, m being 10 or 11
    function [3:0] mod_small;
        input [5:0] x;
        input [3:0] m;
        reg [5:0] y;
        begin
            y = x;
            if (y >= {2'h0, m}) begin
                y = y - {2'h0, m};
            end
            if (y >= {2'h0, m}) begin
                y = y - {2'h0, m};
            end
            mod_small = y[3:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // main-mapping address arithmetic
    // ----------------------------------------------------------------
    assign is_50i = (fmt_r == `FMT_1080_50I);
    assign colmod = is_50i ? `COL_MOD_50I : `COL_MOD_60;
    // linear block position: 5t+25k+675s, or 5i+55k for 1080/50i
    assign lin = is_50i ? (({7'h0, t_r} * 11'd5) + ({6'h0, k_r} * 11'd55)) // R4
               : (({7'h0, t_r} * 11'd5) + ({6'h0, k_r} * 11'd25) + (s_r ? 11'd675 : 11'd0)); // R1
    assign seq_full = lin / 11'd135; // R1 R4
    // quotient never exceeds 10, so the cut to four bits loses nothing
    assign seq_main = seq_full[3:0];
    assign blk_full = lin - seq_full * 11'd135;
    assign blk_base = blk_full[7:0]; // R1 R4
    assign last_u = (u_r == 3'h4);
    assign last_t = is_50i ? (t_r == 4'ha) : (t_r == 4'h4);
    assign last_k = (k_r == `NUM_KORDER - 1'b1);

    // descriptor build: {present, chan, seq, blk, col, pos, k}
    always @* begin
        slot_d = {DW{1'b0}};
        slot_we = 1'b0;
        case (state_r)
            ST_MAIN: begin
                slot_we = 1'b1;
                slot_d = {1'b1, h_r, seq_main, blk_base + {5'h0, u_r}, // R2 R5 R9
                    mod_small({2'h0, h_r, 2'h0} + {2'h0, t_r} + (is_50i ? 6'h0 : {5'h0, s_r})
                        + (is_50i ? {2'h0, col_off(u_r)} : {2'h0, t_r} + {2'h0, col_off(u_r)}), colmod),
                    pos_of(u_r), k_r}; // R1 R4
            end
            ST_EDGE: begin
                slot_we = 1'b1;
                slot_d = {1'b1, 2'h0, `EDGE_SEQ, {k_r, 2'h0} + {3'h0, k_r} + {5'h0, u_r},
                    `EDGE_COLUMN, u_r, k_r}; // R6
            end
            ST_PAD: begin
                slot_we = 1'b1;
                slot_d = {1'b0, h_r, pseq_r, pblk_r, 4'h0, 3'h0, 5'h0}; // R7 R8
            end
            default: begin
                slot_we = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencing state machine
    // ----------------------------------------------------------------
    // the whole walk stalls while the FIFO is full, so nothing is dropped
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_MAIN: begin
                if (fifo_ready && last_u && last_t && last_k && (is_50i || s_r) && h_r == 2'h3) begin
                    if (is_50i) begin
                        state_nxt = ST_EDGE;
                    end else if (fmt_r == `FMT_720_50P) begin
                        state_nxt = ST_PAD;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_EDGE: begin
                if (fifo_ready && last_u && last_k) begin
                    state_nxt = ST_PAD;
                end
            end
            ST_PAD: begin
                if (fifo_ready && pblk_r == `BLOCKS_PER_SEQ - 1'b1 && h_r == 2'h3
                    && pseq_r == `NUM_SEQ_TOTAL - 1'b1) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // loop counters; frame_start restarts all but pseq_r and pblk_r and latches the format
    always @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            fmt_r <= `FMT_60HZ;
            h_r <= 2'h0;
            s_r <= 1'b0;
            k_r <= 5'h0;
            t_r <= 4'h0;
            u_r <= 3'h0;
            pseq_r <= 4'h0;
            pblk_r <= 8'h0;
            frame_done <= 1'b0;
        end else if (frame_start) begin
            state_r <= ST_MAIN; // R12
            fmt_r <= sys_format; // R12
            h_r <= 2'h0;
            s_r <= 1'b0;
            k_r <= 5'h0;
            t_r <= 4'h0;
            u_r <= 3'h0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
            state_r <= state_nxt;
            if (fifo_ready && state_r == ST_MAIN) begin
                // loop order h, s, k, t then five slots (h, k, i for 1080/50i)
                u_r <= last_u ? 3'h0 : u_r + 1'b1;
                if (last_u) begin
                    t_r <= last_t ? 4'h0 : t_r + 1'b1;
                    if (last_t) begin
                        k_r <= last_k ? 5'h0 : k_r + 1'b1;
                        if (last_k) begin
                            s_r <= is_50i ? 1'b0 : ~s_r;
                            if (is_50i || s_r) begin
                                h_r <= h_r + 1'b1; // R3
                            end
                        end
                    end
                end
                // prime the empty-sequence walk
                pseq_r <= is_50i ? `EDGE_SEQ : `NUM_SEQ_USED; // R8
                pblk_r <= 8'h0;
            end else if (fifo_ready && state_r == ST_EDGE) begin
                u_r <= last_u ? 3'h0 : u_r + 1'b1;
                if (last_u) begin
                    k_r <= last_k ? 5'h0 : k_r + 1'b1;
                end
                h_r <= 2'h1; // R7
            end else if (fifo_ready && state_r == ST_PAD) begin
                pblk_r <= (pblk_r == `BLOCKS_PER_SEQ - 1'b1) ? 8'h0 : pblk_r + 1'b1;
                if (pblk_r == `BLOCKS_PER_SEQ - 1'b1) begin
                    if (pseq_r == `NUM_SEQ_TOTAL - 1'b1) begin
                        pseq_r <= is_50i ? `EDGE_SEQ : `NUM_SEQ_USED;
                        h_r <= h_r + 1'b1;
                    end else begin
                        pseq_r <= pseq_r + 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // output buffer
    // ----------------------------------------------------------------
    slot_fifo #(
        .WIDTH(DW),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset | frame_start),
        .wr_valid(slot_we),
        .wr_ready(fifo_ready),
        .wr_data(slot_d),
        .rd_valid(slot_valid),
        .rd_ready(slot_ready),
        .rd_data(fifo_q)
    );

    // slicing follows the descriptor build: present, chan, seq, blk, col, pos, k
    assign mb_present = fifo_q[26];
    assign channel = fifo_q[25:24];
    assign sequence_index = fifo_q[23:20]; // R9
    assign block_index_in_sequence = fifo_q[19:12]; // R9
    assign mb_column = fifo_q[11:8];
    assign mb_position = fifo_q[7:5];
    assign mb_order = fifo_q[4:0];
    assign section_type = `SECTION_VIDEO; // R11
    assign payload_bytes = `PAYLOAD_BYTES; // R10

endmodule

// File: include/blk_mapper_map.vh
// constants for the video block mapper: format codes, loop limits, fifo size
// assumes inclusion by bare name from design files under hdl/
`ifndef BLK_MAPPER_MAP_VH
`define BLK_MAPPER_MAP_VH

// ----------------------------------------------------------------
// system formats
// ----------------------------------------------------------------
`define FMT_60HZ 2'h0
`define FMT_720_50P 2'h1
`define FMT_1080_50I 2'h2

// ----------------------------------------------------------------
// loop limits and block geometry
// ----------------------------------------------------------------
`define NUM_CHANNELS 3'h4
`define NUM_KORDER 5'h1b
`define NUM_SEQ_USED 4'ha
`define NUM_SEQ_TOTAL 4'hc
`define EDGE_SEQ 4'hb
`define BLOCKS_PER_SEQ 8'h87
`define COL_MOD_60 4'ha
`define COL_MOD_50I 4'hb
`define EDGE_COLUMN 4'hb
`define PAYLOAD_BYTES 7'h4d
`define SECTION_VIDEO 3'h4
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// File: hdl/slot_fifo.v
// synchronous FIFO holding mapped block descriptors
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps

module slot_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire reset,
    input wire wr_valid,
    output wire wr_ready,
    input wire [WIDTH-1:0] wr_data,
    output wire rd_valid,
    input wire rd_ready,
    output wire [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire do_wr;
    wire do_rd;

    // ----------------------------------------------------------------
    // handshakes
    // ----------------------------------------------------------------
    assign wr_ready = (cnt_r != DEPTH);
    assign rd_valid = (cnt_r != 0);
    assign do_wr = wr_valid & wr_ready;
    assign do_rd = rd_valid & rd_ready;
    assign rd_data = mem[rp_r];

    // storage has no reset; only pointers and occupancy count need a defined state
    always @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wp_r] <= wr_data;
        end
    end

    // pointer and occupancy update
    always @(posedge sys_clk) begin
        if (reset) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wp_r <= (wp_r == DEPTH-1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (do_rd) begin
                rp_r <= (rp_r == DEPTH-1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_rd & ~do_wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule

// File: dv/mapper_checker.sv
// checker for the block mapper descriptor stream
// assumes binding to the mapper top, ports by name
`timescale 1ns/10ps
module mapper_checker (
    input wire sys_clk,
    input wire reset,
    input wire frame_start,
    input wire slot_valid,
    input wire slot_ready,
    input wire [1:0] channel,
    input wire [3:0] sequence_index,
    input wire [7:0] block_index_in_sequence,
    input wire mb_present,
    input wire [3:0] mb_column,
    input wire [2:0] mb_position,
    input wire [4:0] mb_order,
    input wire [2:0] section_type,
    input wire [6:0] payload_bytes,
    input wire frame_done
);
    // slot inside a five-block group fixes the position
    wire [7:0] slot = block_index_in_sequence % 8'h05;
    wire [2:0] pos_exp = (slot == 0) ? 3'h2 : (slot == 1) ? 3'h1 : (slot == 2) ? 3'h3 : (slot == 3) ? 3'h0 : 3'h4;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_payload_len: assert property (payload_bytes == 7'h4d)
        else $error("payload length wrong");
    chk_section_code: assert property (section_type == 3'h4)
        else $error("section type wrong");
    chk_field_range: assert property (slot_valid |-> block_index_in_sequence <= 8'h86 && sequence_index <= 4'hb)
        else $error("block or sequence out of range");
    chk_slot_position: assert property (slot_valid && mb_present && mb_column != 4'hb |-> mb_position == pos_exp)
        else $error("position does not follow slot");
    chk_edge_unit: assert property (slot_valid && mb_present && sequence_index == 4'hb |->
        channel == 2'h0 && mb_column == 4'hb && mb_position == slot[2:0])
        else $error("edge unit misplaced");
    chk_empty_fields: assert property (slot_valid && !mb_present |-> {mb_column, mb_position, mb_order} == 12'h000)
        else $error("empty block carries fields");
    chk_stall_hold: assert property (slot_valid && !slot_ready && !frame_start |=>
        slot_valid && $stable(block_index_in_sequence) && $stable(sequence_index))
        else $error("descriptor changed while stalled");
    chk_start_latency: assert property (frame_start |=> !slot_valid ##1 slot_valid)
        else $error("first descriptor not two cycles after start");
    chk_reset_idle: assert property (disable iff (1'b0) reset |=> !slot_valid && !frame_done)
        else $error("outputs active after reset");
    chk_done_pulse: assert property (frame_done |=> !frame_done)
        else $error("frame done longer than one cycle");
    cover property (frame_done);
    cover property (slot_valid && !slot_ready);
    cover property (slot_valid && !mb_present);
endmodule

// File: dv/slot_sink.sv
// consumer model for the descriptor stream
// assumes hold comes from the bench off the clock edge
`timescale 1ns/10ps
module slot_sink (
    input wire sys_clk,
    input wire hold,
    input wire slot_valid,
    output reg slot_ready,
    input wire [26:0] desc,
    output reg got,
    output reg [26:0] taken_desc
);
    reg [1:0] tick;
    initial begin
        slot_ready = 1'b0;
        got = 1'b0;
        taken_desc = 27'h0;
        tick = 2'h0;
    end
    // every fourth cycle stalls so the fifo sees back-pressure
    always @(posedge sys_clk) begin
        got <= slot_valid && slot_ready;
        taken_desc <= desc;
        tick <= tick + 2'h1;
        slot_ready <= #1 !hold && tick != 2'h3;
    end
endmodule

// File: dv/testbench.sv
// self-checking bench for the block mapper
// assumes the mapper, its fifo and the sink model are compiled
`timescale 1ns/10ps
module testbench;
    reg sys_clk, reset, frame_start, hold;
    reg [1:0] sys_format;
    wire slot_valid, slot_ready, mb_present, frame_done, got;
    wire [1:0] channel;
    wire [3:0] sequence_index, mb_column;
    wire [7:0] block_index_in_sequence;
    wire [2:0] mb_position, section_type;
    wire [4:0] mb_order;
    wire [6:0] payload_bytes;
    wire [26:0] taken_desc;
    wire [26:0] desc = {channel, sequence_index, block_index_in_sequence, mb_present, mb_column, mb_position, mb_order};
    integer n_fail, samples_checked, dones, cyc, taken, limit;
    video_dif_block_mapper dut (.sys_clk(sys_clk), .reset(reset), .frame_start(frame_start),
        .sys_format(sys_format), .slot_valid(slot_valid), .slot_ready(slot_ready), .channel(channel),
        .sequence_index(sequence_index), .block_index_in_sequence(block_index_in_sequence),
        .mb_present(mb_present), .mb_column(mb_column), .mb_position(mb_position), .mb_order(mb_order),
        .section_type(section_type), .payload_bytes(payload_bytes), .frame_done(frame_done));
    slot_sink sink (.sys_clk(sys_clk), .hold(hold), .slot_valid(slot_valid), .slot_ready(slot_ready),
        .desc(desc), .got(got), .taken_desc(taken_desc));
    task give_verdict;
        begin
            if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task check(input [31:0] act, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (act !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %0t seen %h expected %h", $time, act, exp);
            end
        end
    endtask
    function integer off(input integer j);
        off = (j == 0) ? 2 : (j == 1) ? 6 : (j == 2) ? 8 : (j == 3) ? 0 : 4;
    endfunction
    function integer psn(input integer j);
        psn = (j == 0) ? 2 : (j == 1) ? 1 : (j == 2) ? 3 : (j == 3) ? 0 : 4;
    endfunction
    // wait for the next accepted descriptor and compare it
    task want(input integer ch, sq, bl, pr, co, po, ko);
        begin
            if (taken < limit) begin
                taken = taken + 1;
                @(posedge sys_clk);
                #2;
                while (got !== 1'b1) begin
                    @(posedge sys_clk);
                    #2;
                end
                check({5'h0, taken_desc}, {5'h0, ch[1:0], sq[3:0], bl[7:0], pr[0], co[3:0], po[2:0], ko[4:0]});
                check({22'h0, section_type, payload_bytes}, {22'h0, 3'h4, 7'h4d});
            end
        end
    endtask
    // expected walk of one frame in the agreed order
    task expect_frame(input [1:0] fmt);
        integer h, s, k, t, j, b;
        begin
            if (fmt == 2'h2) begin
                for (h = 0; h < 4; h++) for (k = 0; k < 27; k++) for (t = 0; t < 11; t++) for (j = 0; j < 5; j++)
                    want(h, (5*t+55*k)/135, (5*t+55*k)%135+j, 1, (4*h+t+off(j))%11, psn(j), k);
                for (k = 0; k < 27; k++) for (j = 0; j < 5; j++) want(0, 11, 5*k+j, 1, 11, j, k);
                for (h = 1; h < 4; h++) for (b = 0; b < 135; b++) want(h, 11, b, 0, 0, 0, 0);
            end else begin
                for (h = 0; h < 4; h++) for (s = 0; s < 2; s++) for (k = 0; k < 27; k++) for (t = 0; t < 5; t++)
                    for (j = 0; j < 5; j++)
                        want(h, (5*t+25*k+675*s)/135, (5*t+25*k)%135+j, 1, (4*h+s+2*t+off(j))%10, psn(j), k);
                if (fmt == 2'h1) for (h = 0; h < 4; h++) for (s = 10; s < 12; s++) for (b = 0; b < 135; b++)
                    want(h, s, b, 0, 0, 0, 0);
            end
        end
    endtask
    // format changes right after start must not disturb the walk
    task start(input [1:0] fmt);
        begin
            @(posedge sys_clk);
            #1 sys_format = fmt;
            frame_start = 1'b1;
            @(posedge sys_clk);
            #1 frame_start = 1'b0;
            sys_format = fmt ^ 2'h1;
        end
    endtask
    task run_frame(input [1:0] fmt);
        integer d0;
        begin
            d0 = dones;
            limit = 99999;
            taken = 0;
            start(fmt);
            expect_frame(fmt);
            check({31'h0, slot_valid}, 32'h0);
            check(dones - d0, 1);
        end
    endtask
    // fill the fifo with the sink stalled, then abort the walk midway
    task abort_walk;
        begin
            limit = 12;
            taken = 0;
            hold = 1'b1;
            start(2'h0);
            repeat (20) @(posedge sys_clk);
            #1 check({31'h0, slot_valid}, 32'h1);
            hold = 1'b0;
            expect_frame(2'h0);
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // hang guard well above the longest expected run
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (frame_done === 1'b1) dones = dones + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end
    initial begin
        reset = 1'b1;
        frame_start = 1'b0;
        sys_format = 2'h0;
        hold = 1'b0;
        {n_fail, samples_checked, dones, cyc, taken, limit} = 0;
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        abort_walk;
        run_frame(2'h2);
        run_frame(2'h0);
        run_frame(2'h1);
        run_frame(2'h3);
        give_verdict;
    end
endmodule
bind video_dif_block_mapper mapper_checker chk (.sys_clk(sys_clk), .reset(reset), .frame_start(frame_start),
    .slot_valid(slot_valid), .slot_ready(slot_ready), .channel(channel), .sequence_index(sequence_index),
    .block_index_in_sequence(block_index_in_sequence), .mb_present(mb_present), .mb_column(mb_column),
    .mb_position(mb_position), .mb_order(mb_order), .section_type(section_type),
    .payload_bytes(payload_bytes), .frame_done(frame_done));
